// ### verilog/tapio_front_end.sv
// Two-axis pulse I/O front end: input qualification, pulse generation, AHB-Lite registers.
// Assumes pins synchronous-safe after a two-stage synchroniser and one AHB-Lite master.
//
// Contract
// - Limit inputs detected on their falling edge.
// - Dog rising edge counted only while homing.
// - Home reference rising edge acted on while homing.
// - Pulse-plus-direction: pulses plus direction level.
// - CW/CCW mode: CW on pulse, CCW on direction.
// - Standard variant offers pulse-plus-direction only.
// - Two independent axes, X and Y.
// - Pulse rate 1 to 100000 pps, 1 pps steps.

`timescale 1ns/1ps
`default_nettype none

module tapio_axis #(
    parameter int RATE_W = tapio_pkg::RATE_W,
    parameter int ACC_W  = tapio_pkg::ACC_W
) (
    // Clock and reset
    input  wire logic                hclk,
    input  wire logic                hresetn,
    // Control
    input  wire tapio_pkg::tapio_cfg_s cfg,
    input  wire logic [RATE_W-1:0]   rate,
    // Pins and qualified results
    input  wire tapio_pkg::tapio_sig_s pins,
    output var  tapio_pkg::tapio_sig_s lvl,
    output var  tapio_pkg::tapio_sig_s ev,
    output var  logic                pulse_o,
    output var  logic                dir_o
);

    localparam logic [ACC_W-1:0] CLK_CNT = ACC_W'(tapio_pkg::CLK_HZ);

    tapio_pkg::tapio_sig_s sync1_r, sync2_r, prev_r, ev_nxt;
    logic [ACC_W-1:0]      acc_r, acc_nxt, acc_sum;
    logic                  phase_r, phase_nxt, pulse_nxt, dir_nxt;

    // ------------------------------------------------------------
    // Input qualification
    // ------------------------------------------------------------
    always_comb begin
        ev_nxt = '0;
        ev_nxt.lower_travel_limit = prev_r.lower_travel_limit & ~sync2_r.lower_travel_limit;
        ev_nxt.upper_travel_limit = prev_r.upper_travel_limit & ~sync2_r.upper_travel_limit;
        ev_nxt.dog = cfg.homing & ~prev_r.dog & sync2_r.dog;
        ev_nxt.home_reference_input = cfg.homing & ~prev_r.home_reference_input
                                      & sync2_r.home_reference_input;
    end

    // ------------------------------------------------------------
    // Pulse generator
    // ------------------------------------------------------------
    // Phase accumulator: two half periods per pulse, so the step is twice the rate
    always_comb begin
        acc_sum   = acc_r + {{(ACC_W-RATE_W-1){1'b0}}, rate, 1'b0};
        acc_nxt   = '0;
        phase_nxt = 1'b0;
        if (cfg.run) begin
            if (acc_sum >= CLK_CNT) begin
                acc_nxt   = acc_sum - CLK_CNT;
                phase_nxt = ~phase_r;
            end else begin
                acc_nxt   = acc_sum;
                phase_nxt = phase_r;
            end
        end
        if (cfg.ccw_mode) begin
            pulse_nxt = phase_r & ~cfg.dir;
            dir_nxt   = phase_r & cfg.dir;
        end else begin
            pulse_nxt = phase_r;
            dir_nxt   = cfg.dir;
        end
        pulse_nxt = cfg.pulse_pol ? pulse_nxt : ~pulse_nxt;
        dir_nxt   = cfg.dir_pol ? dir_nxt : ~dir_nxt;
    end

    // First stage feeds only the second stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r  <= '0;
            ev      <= '0;
            acc_r   <= '0;
            phase_r <= 1'b0;
            pulse_o <= 1'b0;
            dir_o   <= 1'b0;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
            ev      <= ev_nxt;
            acc_r   <= acc_nxt;
            phase_r <= phase_nxt;
            pulse_o <= pulse_nxt;
            dir_o   <= dir_nxt;
        end
    end

    assign lvl = sync2_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_lower_fall_event:
        assert property ($fell(pins.lower_travel_limit) |-> ##3 ev.lower_travel_limit)
        else $error("lower limit fall gave no event");
    a_upper_rise_quiet:
        assert property ($rose(pins.upper_travel_limit) |-> ##3 !ev.upper_travel_limit)
        else $error("upper limit rise gave an event");
    a_dog_only_homing:
        assert property (ev.dog |-> $past(cfg.homing))
        else $error("dog event outside homing");
    a_home_ref_edge:
        assert property (($rose(pins.home_reference_input) ##2 cfg.homing) |-> ##1 ev.home_reference_input)
        else $error("home reference edge missed");
    a_event_single_cycle:
        assert property (ev.lower_travel_limit |=> !ev.lower_travel_limit)
        else $error("limit event longer than one cycle");
    a_idle_pulse_level:
        assert property ((!cfg.run && $stable(cfg.pulse_pol))[*3] |-> pulse_o == !cfg.pulse_pol)
        else $error("idle pulse level ignores polarity");
    // Three samples: the output still shows its reset value one cycle after release
    a_pd_dir_level:
        assert property ((!cfg.ccw_mode && $stable(cfg))[*3] |-> dir_o == (cfg.dir ~^ cfg.dir_pol))
        else $error("direction level wrong");
    a_cw_dir_silent:
        assert property ((cfg.ccw_mode && !cfg.dir && $stable(cfg))[*2] |-> dir_o == !cfg.dir_pol)
        else $error("CCW output pulsed during CW travel");
    a_ccw_pulse_silent:
        assert property ((cfg.ccw_mode && cfg.dir && $stable(cfg))[*2] |-> pulse_o == !cfg.pulse_pol)
        else $error("CW output pulsed during CCW travel");
    a_upper_fall_event:
        assert property ($fell(pins.upper_travel_limit) |-> ##3 ev.upper_travel_limit)
        else $error("upper limit fall gave no event");
    a_lower_rise_quiet:
        assert property ($rose(pins.lower_travel_limit) |-> ##3 !ev.lower_travel_limit)
        else $error("lower limit rise gave an event");
    a_dog_edge_homing:
        assert property (($rose(pins.dog) ##2 cfg.homing) |-> ##1 ev.dog)
        else $error("dog edge during homing missed");
    a_home_ref_homing:
        assert property (ev.home_reference_input |-> $past(cfg.homing))
        else $error("home reference event outside homing");
    a_upper_single_cycle:
        assert property (ev.upper_travel_limit |=> !ev.upper_travel_limit)
        else $error("limit event longer than one cycle");
    a_dog_single_cycle:
        assert property (ev.dog |=> !ev.dog)
        else $error("dog event longer than one cycle");

endmodule // tapio_axis

module tapio_front_end #(
    parameter bit HIGH_END = 1'b1
) (
    // Clock and reset
    input  wire logic                                        hclk,
    input  wire logic                                        hresetn,
    // AHB-Lite slave
    input  wire logic                                        hsel,
    input  wire logic [31:0]                                 haddr,
    input  wire logic [1:0]                                  htrans,
    input  wire logic                                        hwrite,
    input  wire logic [2:0]                                  hsize,
    input  wire logic [31:0]                                 hwdata,
    input  wire logic                                        hready,
    output var  logic                                        hreadyout,
    output var  logic                                        hresp,
    output var  logic [31:0]                                 hrdata,
    // Axis pins, index 0 is X, 1 is Y
    input  wire tapio_pkg::tapio_sig_s [tapio_pkg::NUM_AXES-1:0] axis_in,
    output var  logic [tapio_pkg::NUM_AXES-1:0]              pulse_out,
    output var  logic [tapio_pkg::NUM_AXES-1:0]              dir_out,
    // Interrupt
    output var  logic                                        irq
);

    localparam int NA = tapio_pkg::NUM_AXES;
    localparam int RW = tapio_pkg::RATE_W;
    localparam int EW = tapio_pkg::EV_W;

    logic                    pend_r, pend_nxt, wr_r, wr_nxt, rdy_nxt, irq_nxt;
    logic [tapio_pkg::ADDR_W-1:0] addr_r, addr_nxt;
    logic [31:0]             rdata_nxt;
    logic [15:0]             ctrl_r, ctrl_nxt;
    logic [NA-1:0][RW-1:0]   rate_r, rate_nxt;
    logic [7:0]              sts_r, sts_nxt, en_r, en_nxt, clr;
    logic [RW-1:0]           wrate;
    tapio_pkg::tapio_cfg_s [NA-1:0] cfg;
    tapio_pkg::tapio_sig_s [NA-1:0] lvl, ev;
    logic [NA-1:0]           run_bits;

    // ------------------------------------------------------------
    // Axes
    // ------------------------------------------------------------
    for (genvar i = 0; i < NA; i++) begin : g_axis
        always_comb begin
            cfg[i] = ctrl_r[i*tapio_pkg::CTRL_STRIDE +: tapio_pkg::CFG_W];
            // Standard variant cannot leave pulse-plus-direction
            cfg[i].ccw_mode = ctrl_r[i*tapio_pkg::CTRL_STRIDE + tapio_pkg::CTRL_CCW_BIT] & HIGH_END;
        end
        assign run_bits[i] = cfg[i].run;

        tapio_axis u_axis (
            .hclk    (hclk),
            .hresetn (hresetn),
            .cfg     (cfg[i]),
            .rate    (rate_r[i]),
            .pins    (axis_in[i]),
            .lvl     (lvl[i]),
            .ev      (ev[i]),
            .pulse_o (pulse_out[i]),
            .dir_o   (dir_out[i])
        );
    end

    // ------------------------------------------------------------
    // Bus slave and registers
    // ------------------------------------------------------------
    // One wait state per transfer keeps hrdata registered and read-after-write coherent
    always_comb begin
        pend_nxt  = 1'b0;
        wr_nxt    = wr_r;
        addr_nxt  = addr_r;
        rdy_nxt   = 1'b1;
        rdata_nxt = hrdata;
        ctrl_nxt  = ctrl_r;
        rate_nxt  = rate_r;
        en_nxt    = en_r;
        clr       = '0;
        wrate     = hwdata[RW-1:0];
        if (hsel && htrans[1] && hready && !pend_r) begin
            pend_nxt = 1'b1;
            wr_nxt   = hwrite;
            addr_nxt = haddr[tapio_pkg::ADDR_W-1:0];
            rdy_nxt  = 1'b0;
        end
        // Out-of-range rates are clamped so a zero step never stalls an axis
        if (hwdata[31:RW] != '0 || wrate > tapio_pkg::RATE_MAX) begin
            wrate = tapio_pkg::RATE_MAX;
        end else if (wrate < tapio_pkg::RATE_MIN) begin
            wrate = tapio_pkg::RATE_MIN;
        end
        if (pend_r && wr_r) begin
            case (addr_r)
                tapio_pkg::A_CTRL:    ctrl_nxt    = hwdata[15:0];
                tapio_pkg::A_RATE_X:  rate_nxt[0] = wrate;
                tapio_pkg::A_RATE_Y:  rate_nxt[1] = wrate;
                tapio_pkg::A_IRQ_CLR: clr         = hwdata[7:0];
                tapio_pkg::A_IRQ_EN:  en_nxt      = hwdata[7:0];
                default: ;
            endcase
        end else if (pend_r) begin
            case (addr_r)
                tapio_pkg::A_CTRL:    rdata_nxt = {16'h0000, ctrl_r};
                tapio_pkg::A_RATE_X:  rdata_nxt = {{(32-RW){1'b0}}, rate_r[0]};
                tapio_pkg::A_RATE_Y:  rdata_nxt = {{(32-RW){1'b0}}, rate_r[1]};
                tapio_pkg::A_LEVELS:  rdata_nxt = {22'h000000, run_bits, lvl};
                tapio_pkg::A_IRQ_STS: rdata_nxt = {24'h000000, sts_r};
                tapio_pkg::A_IRQ_EN:  rdata_nxt = {24'h000000, en_r};
                default:              rdata_nxt = 32'h00000000;
            endcase
        end
        // A limit reached stops that axis, even against a same-cycle write
        for (int i = 0; i < NA; i++) begin
            if (ev[i].lower_travel_limit || ev[i].upper_travel_limit) begin
                ctrl_nxt[i*tapio_pkg::CTRL_STRIDE + tapio_pkg::CTRL_RUN_BIT] = 1'b0;
            end
        end
        // New events win over a clear in the same cycle
        sts_nxt = (sts_r & ~clr) | ev;
        irq_nxt = |(sts_r & en_r);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_r    <= 1'b0;
            wr_r      <= 1'b0;
            addr_r    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h00000000;
            ctrl_r    <= tapio_pkg::CTRL_RESET;
            rate_r    <= {NA{tapio_pkg::RATE_MIN}};
            sts_r     <= tapio_pkg::IRQ_RESET;
            en_r      <= tapio_pkg::IRQ_RESET;
            irq       <= 1'b0;
        end else begin
            pend_r    <= pend_nxt;
            wr_r      <= wr_nxt;
            addr_r    <= addr_nxt;
            hreadyout <= rdy_nxt;
            hresp     <= 1'b0;
            hrdata    <= rdata_nxt;
            ctrl_r    <= ctrl_nxt;
            rate_r    <= rate_nxt;
            sts_r     <= sts_nxt;
            en_r      <= en_nxt;
            irq       <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_rate_in_range:
        assert property (@(posedge hclk) disable iff (!hresetn)
            rate_r[0] >= tapio_pkg::RATE_MIN && rate_r[0] <= tapio_pkg::RATE_MAX
            && rate_r[1] >= tapio_pkg::RATE_MIN && rate_r[1] <= tapio_pkg::RATE_MAX)
        else $error("pulse rate out of range");
    a_std_no_ccw:
        assert property (@(posedge hclk) disable iff (!hresetn)
            !HIGH_END |-> !cfg[0].ccw_mode && !cfg[1].ccw_mode)
        else $error("standard variant in CW/CCW mode");
    a_limit_stops_axis:
        assert property (@(posedge hclk) disable iff (!hresetn)
            ev[1].upper_travel_limit |=> !cfg[1].run)
        else $error("Y axis runs past its limit");
    a_event_kept_sticky:
        assert property (@(posedge hclk) disable iff (!hresetn)
            ev[0].dog |=> sts_r[2] ##1 irq == en_r[2])
        else $error("dog event not latched or not signalled");
    a_limit_stops_x:
        assert property (@(posedge hclk) disable iff (!hresetn)
            ev[0].lower_travel_limit |=> !cfg[0].run)
        else $error("X axis runs past its limit");
    a_home_ref_sticky:
        assert property (@(posedge hclk) disable iff (!hresetn)
            ev[1].home_reference_input |=> sts_r[7])
        else $error("home reference event not latched");

endmodule // tapio_front_end

`default_nettype wire

// ### common/tapio_pkg.sv
// Shared constants and carriers for the two-axis pulse I/O front end.
// Assumes a 100 MHz hclk and a single AHB-Lite master.

package tapio_pkg;

    // ------------------------------------------------------------
    // Clock and rates
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_S      = 1000000000;
    localparam int CLK_HZ        = NS_PER_S / CLK_PERIOD_NS;
    localparam int NUM_AXES      = 2;
    localparam int RATE_W        = 17;
    localparam int ACC_W         = 28;
    localparam logic [RATE_W-1:0] RATE_MIN = 17'h00001;
    localparam logic [RATE_W-1:0] RATE_MAX = 17'h186A0;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] A_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] A_RATE_X  = 8'h04;
    localparam logic [ADDR_W-1:0] A_RATE_Y  = 8'h08;
    localparam logic [ADDR_W-1:0] A_LEVELS  = 8'h0C;
    localparam logic [ADDR_W-1:0] A_IRQ_STS = 8'h10;
    localparam logic [ADDR_W-1:0] A_IRQ_CLR = 8'h14;
    localparam logic [ADDR_W-1:0] A_IRQ_EN  = 8'h18;

    // Control: one byte per axis, X in the low byte
    localparam int CTRL_STRIDE  = 8;
    localparam int CFG_W        = 6;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_CCW_BIT = 2;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam int EV_W = 4;
    localparam logic [7:0] IRQ_RESET = 8'h00;
    localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic dir_pol;    // 1: direction output active high
        logic pulse_pol;  // 1: pulse output active high
        logic homing;     // Homing in progress
        logic ccw_mode;   // 1: CW/CCW pulses, 0: pulse plus direction
        logic dir;        // 1: counter-clockwise travel
        logic run;        // Emit pulses
    } tapio_cfg_s;

    // Same layout for pins, synced levels and events
    typedef struct packed {
        logic home_reference_input;
        logic dog;
        logic upper_travel_limit;
        logic lower_travel_limit;
    } tapio_sig_s;

endpackage

// ### tb/tapio_far_side.sv
// Far-side model: limit, dog and home-reference contacts plus a drive that counts output edges.
// Assumes the bench sets contact states and reads the counts; one clock, no reset needed.

`timescale 1ns/1ps
`default_nettype none

module tapio_far_side (
    // Clock
    input  wire logic                        hclk,
    // Contact states and count clear from the bench
    input  wire tapio_pkg::tapio_sig_s [1:0] sw_cmd,
    input  wire logic                        clr_cnt,
    // Drive inputs: main X, main Y, standard X, standard Y
    input  wire logic [3:0]                  pulse_in,
    input  wire logic [3:0]                  dir_in,
    // Contacts towards the device and edge counts
    output var  tapio_pkg::tapio_sig_s [1:0] axis_in,
    output var  int                          pul_cnt [4],
    output var  int                          dir_cnt [4]
);
    logic [3:0] pulse_q;
    logic [3:0] dir_q;

    // Contacts move just after an edge; polarity free, so toggles are counted
    always_ff @(posedge hclk) begin
        axis_in <= sw_cmd;
        pulse_q <= pulse_in;
        dir_q   <= dir_in;
        for (int i = 0; i < 4; i++) begin
            pul_cnt[i] <= clr_cnt ? 0 : pul_cnt[i] + int'(pulse_in[i] !== pulse_q[i]);
            dir_cnt[i] <= clr_cnt ? 0 : dir_cnt[i] + int'(dir_in[i] !== dir_q[i]);
        end
    end
endmodule // tapio_far_side

`default_nettype wire

// ### tb/tapio_front_end_bench.sv
// Self-checking bench for the two-axis pulse front end, high-end and standard builds side by side.
// Assumes a single AHB-Lite master (this bench) and the far-side contact and drive model.

`timescale 1ns/1ps
`default_nettype none

module tapio_front_end_bench;
    logic                        hclk;
    logic                        hresetn;
    logic                        hsel;
    logic [31:0]                 haddr;
    logic [1:0]                  htrans;
    logic                        hwrite;
    logic [31:0]                 hwdata;
    wire logic                   hready;
    wire logic                   hrdy_std;
    wire logic                   hresp;
    wire logic [31:0]            hrdata;
    wire logic                   irq;
    wire logic [1:0]             pulse_out;
    wire logic [1:0]             dir_out;
    wire logic [1:0]             pulse_std;
    wire logic [1:0]             dir_std;
    wire tapio_pkg::tapio_sig_s [1:0] axis_in;
    tapio_pkg::tapio_sig_s [1:0] sw;
    logic                        clr_cnt;
    int                          pul_cnt [4];
    int                          dir_cnt [4];
    int                          error_cnt;
    int                          samples_checked;
    logic [31:0]                 rdv;
    logic [4:0]                  r;
    logic [7:0]                  ev;
    logic [1:0]                  run;
    // Rows: {axis, signal, homing, event expected}
    logic [4:0]  rows [12]    = '{5'h01, 5'h05, 5'h08, 5'h0B, 5'h0C, 5'h0F,
                                  5'h11, 5'h15, 5'h18, 5'h1B, 5'h1C, 5'h1F};
    logic [31:0] rst_exp [8]  = '{32'h0, 32'h1, 32'h1, 32'h33, 32'h0, 32'h0, 32'h0, 32'h0};

    tapio_front_end u_tapio_front_end (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .axis_in(axis_in),
        .pulse_out(pulse_out), .dir_out(dir_out), .irq(irq));
    tapio_front_end #(.HIGH_END(1'b0)) u_tapio_front_end_std (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hrdy_std), .hreadyout(hrdy_std), .hresp(), .hrdata(), .axis_in(axis_in),
        .pulse_out(pulse_std), .dir_out(dir_std), .irq());
    tapio_far_side u_tapio_far_side (.hclk(hclk), .sw_cmd(sw), .clr_cnt(clr_cnt),
        .pulse_in({pulse_std, pulse_out}), .dir_in({dir_std, dir_out}), .axis_in(axis_in),
        .pul_cnt(pul_cnt), .dir_cnt(dir_cnt));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Accumulator phase makes a window count off by one either way
    task automatic rng(input int got, input int e);
        samples_checked++;
        if (got < e - int'(e > 0) || got > e + int'(e > 0)) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 40);
        if (hready !== 1'b1) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, hready, 1'b1);
            wrap_up();
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= tapio_pkg::HTRANS_NONSEQ_BIT;
        hwrite <= wr;
        haddr  <= {24'h000000, a};
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rdv = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask

    task automatic pulse_win();
        cyc(10);
        clr_cnt <= 1'b1;
        cyc(1);
        clr_cnt <= 1'b0;
        cyc(3000);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        clr_cnt = 1'b0;
        sw = 8'h33;
        error_cnt = 0;
        samples_checked = 0;
        cyc(8);
        hresetn <= 1'b1;
        cyc(1);
        wr(tapio_pkg::A_IRQ_EN, 32'hFF);
        for (int i = 0; i < 12; i++) begin
            r = rows[i];
            wr(tapio_pkg::A_CTRL, r[1] ? (r[4] ? 32'h0901 : 32'h0109) : 32'h0101);
            sw[r[4]][r[3:2]] <= ~sw[r[4]][r[3:2]];
            cyc(8);
            ev = r[0] ? 8'h01 << {r[4], r[3:2]} : 8'h00;
            rd_chk(tapio_pkg::A_IRQ_STS, {24'h0, ev});
            chk({31'h0, irq}, {31'h0, r[0]});
            run = 2'b11;
            if (r[0] && !r[3]) begin
                run[r[4]] = 1'b0;
            end
            rd_chk(tapio_pkg::A_LEVELS, {22'h0, run, sw});
            wr(tapio_pkg::A_IRQ_CLR, 32'hFF);
            sw[r[4]][r[3:2]] <= ~sw[r[4]][r[3:2]];
            cyc(8);
            rd_chk(tapio_pkg::A_IRQ_STS, 32'h0);
        end
        // Masked event, then enable and clear
        wr(tapio_pkg::A_IRQ_EN, 32'h0);
        sw[0].lower_travel_limit <= 1'b0;
        cyc(8);
        chk({31'h0, irq}, 32'h0);
        rd_chk(tapio_pkg::A_IRQ_STS, 32'h1);
        wr(tapio_pkg::A_IRQ_EN, 32'h1);
        cyc(2);
        chk({31'h0, irq}, 32'h1);
        wr(tapio_pkg::A_IRQ_CLR, 32'h1);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        sw[0].lower_travel_limit <= 1'b1;
        // Rate clamping at both ends
        wr(tapio_pkg::A_RATE_X, 32'h0);
        rd_chk(tapio_pkg::A_RATE_X, 32'h1);
        wr(tapio_pkg::A_RATE_X, 32'h186A1);
        rd_chk(tapio_pkg::A_RATE_X, 32'h186A0);
        wr(tapio_pkg::A_RATE_X, 32'hFFFFFFFF);
        rd_chk(tapio_pkg::A_RATE_X, 32'h186A0);
        wr(tapio_pkg::A_RATE_Y, 32'hC350);
        rd_chk(tapio_pkg::A_RATE_Y, 32'hC350);
        // Pulse plus direction, mixed polarity per axis
        wr(tapio_pkg::A_CTRL, 32'h2331);
        pulse_win();
        rng(pul_cnt[0], 6);
        rng(pul_cnt[1], 3);
        rng(dir_cnt[0] + dir_cnt[1], 0);
        chk({30'h0, dir_out}, 32'h2);
        // CW/CCW mode; the standard build must stay in pulse plus direction
        wr(tapio_pkg::A_CTRL, 32'h0537);
        pulse_win();
        rng(pul_cnt[0], 0);
        rng(dir_cnt[0], 6);
        rng(pul_cnt[1], 3);
        rng(dir_cnt[1], 0);
        chk({30'h0, pulse_out[0], dir_out[1]}, 32'h1);
        rng(pul_cnt[2], 6);
        rng(pul_cnt[3], 3);
        rng(dir_cnt[2] + dir_cnt[3], 0);
        chk({30'h0, dir_std}, 32'h3);
        // Reset in mid-run, then reset values and refused writes
        hresetn <= 1'b0;
        cyc(3);
        hresetn <= 1'b1;
        cyc(3);
        chk({28'h0, dir_out, pulse_out}, 32'hF);
        wr(tapio_pkg::A_IRQ_STS, 32'hFF);
        wr(8'h1C, 32'hFF);
        for (int i = 0; i < 8; i++) begin
            rd_chk(8'(4 * i), rst_exp[i]);
        end
        wrap_up();
    end
endmodule // tapio_front_end_bench

`default_nettype wire
